// ===== src/pcr_pkg.sv
package pcr_pkg;
  // -------------------------------------------------------------------
  // register offsets (printed offsets are not multiples of four: index)
  // -------------------------------------------------------------------
  localparam logic [7:0] IDX_PORT0_OUTPUT_ENABLE = 8'h91;
  localparam logic [7:0] IDX_PORT0_LCD_BIAS_ENABLE = 8'h92;
  localparam logic [7:0] IDX_PORT2_PIN_MODE = 8'h93;
  localparam logic [7:0] IDX_SYSTEM_CONFIG_BITS = 8'h94;
  localparam int ADDR_W = 12;

  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int PIN21_MODE_LSB = 2;
  localparam int PIN20_MODE_LSB = 0;
  localparam int SINGLE_WIRE_UART_BIT = 7;
  localparam int TOUCH_CLOCK_ADJUST_BIT = 6;
  localparam int WATCHDOG_PERIOD_LSB = 4;
  localparam int ADC_CLOCK_DIV_LSB = 2;
  localparam int TIMER3_PERIOD_LSB = 0;

  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_PORT0_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0] RST_PORT0_LCD_BIAS_ENABLE = 8'h00;
  localparam logic [7:0] RST_PORT2_PIN_MODE = 8'h05;
  localparam logic [7:0] RST_SYSTEM_CONFIG_BITS = 8'h00;

  // -------------------------------------------------------------------
  // undefined pin mode code and decoded periods
  // -------------------------------------------------------------------
  localparam logic [1:0] PIN_MODE_UNDEFINED = 2'h3;
  localparam logic [8:0] WDT_PERIOD_MS_0 = 9'd480;
  localparam logic [8:0] WDT_PERIOD_MS_1 = 9'd240;
  localparam logic [8:0] WDT_PERIOD_MS_2 = 9'd120;
  localparam logic [8:0] WDT_PERIOD_MS_3 = 9'd60;
  localparam logic [15:0] T3_PERIOD_0 = 16'd32768;
  localparam logic [15:0] T3_PERIOD_1 = 16'd8192;
  localparam logic [15:0] T3_PERIOD_2 = 16'd2048;
  localparam logic [15:0] T3_PERIOD_3 = 16'd128;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== src/pcr_decode.sv
`timescale 1ns/1ps
// -------------------------------------------------------------------
// option decoder: turns the option register into period figures
// -------------------------------------------------------------------
module pcr_decode (
  input wire logic [7:0] opt,
  input wire logic [7:0] pmode,
  output logic [8:0] wdt_ms,
  output logic [15:0] t3_cycles,
  output logic [1:0] pin_undef
);
  genvar g;

  always_comb begin
    case (opt[pcr_pkg::WATCHDOG_PERIOD_LSB +: 2])
      2'h0: wdt_ms = pcr_pkg::WDT_PERIOD_MS_0;
      2'h1: wdt_ms = pcr_pkg::WDT_PERIOD_MS_1;
      2'h2: wdt_ms = pcr_pkg::WDT_PERIOD_MS_2;
      default: wdt_ms = pcr_pkg::WDT_PERIOD_MS_3;
    endcase
    case (opt[pcr_pkg::TIMER3_PERIOD_LSB +: 2])
      2'h0: t3_cycles = pcr_pkg::T3_PERIOD_0;
      2'h1: t3_cycles = pcr_pkg::T3_PERIOD_1;
      2'h2: t3_cycles = pcr_pkg::T3_PERIOD_2;
      default: t3_cycles = pcr_pkg::T3_PERIOD_3;
    endcase
  end

  // code 11 has no defined pin mode; flag it so pad logic can hold off
  for (g = 0; g < 2; g++) begin : g_pin
    assign pin_undef[g] = (pmode[2*g +: 2] == pcr_pkg::PIN_MODE_UNDEFINED);
  end
endmodule

// ===== src/pcr_regs.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Function
// R1: LCD half-bias enable byte, resets zero
// R2: two pin mode fields, reset 01
// R3: option bit 7 selects single-wire UART
// R4: option bit 6 enables touch clock adjust
// R5: watchdog period select 480/240/120/60 ms
// R6: Timer3 period select 32768 to 128
// R7: writes act next cycle, reads return value
module pcr_regs (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [7:0] PORT0_OUTPUT_ENABLE,
  output logic [7:0] PORT0_LCD_BIAS_ENABLE,
  output logic [1:0] PIN21_MODE_FIELD,
  output logic [1:0] PIN20_MODE_FIELD,
  output logic [1:0] PIN_MODE_UNDEFINED,
  output logic SINGLE_WIRE_UART_ENABLE,
  output logic TOUCH_CLOCK_AUTO_ADJUST,
  output logic [1:0] WATCHDOG_PERIOD_SELECT,
  output logic [1:0] ADC_CLOCK_DIV_SELECT,
  output logic [1:0] TIMER3_PERIOD_SELECT,
  output logic [8:0] WATCHDOG_PERIOD_MS,
  output logic [15:0] TIMER3_PERIOD_CYCLES
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] bias;
    logic [7:0] pmode;
    logic [7:0] opt;
    // bus side: the halves of a write may arrive in either order
    logic aw_held;
    logic [9:0] aw_idx;
    logic aw_ok;
    logic w_held;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } pcr_state_t;

  pcr_state_t s;
  pcr_state_t next_s;
  logic [8:0] wdt_ms;
  logic [15:0] t3_cycles;
  logic [1:0] pin_undef;

  // -------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------
  // the printed offsets are word indexes; anything else answers SLVERR
  function automatic logic idx_ok(input logic [9:0] idx);
    idx_ok = (idx == 10'(pcr_pkg::IDX_PORT0_OUTPUT_ENABLE)) ||
             (idx == 10'(pcr_pkg::IDX_PORT0_LCD_BIAS_ENABLE)) ||
             (idx == 10'(pcr_pkg::IDX_PORT2_PIN_MODE)) ||
             (idx == 10'(pcr_pkg::IDX_SYSTEM_CONFIG_BITS));
  endfunction

  // -------------------------------------------------------------------
  // bus channels: address and data may arrive in either order
  // -------------------------------------------------------------------
  // readies stay low while a response waits: one write in flight at most
  assign S_AXI_AWREADY = !s.aw_held && !s.bvalid;
  assign S_AXI_WREADY = !s.w_held && !s.bvalid;
  assign S_AXI_ARREADY = !s.rvalid;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RRESP = s.rresp;
  assign S_AXI_RDATA = s.rdata;

  always_comb begin
    logic aw_now;
    logic [9:0] aw_idx;
    logic aw_ok;
    logic w_now;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [9:0] r_idx;
    logic [7:0] r_val;
    aw_now = 1'b0;
    aw_idx = 10'h000;
    aw_ok = 1'b0;
    w_now = 1'b0;
    w_byte = 8'h00;
    w_lane0 = 1'b0;
    r_idx = 10'h000;
    r_val = 8'h00;
    next_s = s;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx = S_AXI_AWADDR[11:2];
      next_s.aw_ok = idx_ok(S_AXI_AWADDR[11:2]);
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_s.w_held = 1'b1;
      next_s.w_byte = S_AXI_WDATA[7:0];
      next_s.w_lane0 = S_AXI_WSTRB[0];
    end
    aw_now = next_s.aw_held;
    aw_idx = next_s.aw_idx;
    aw_ok = next_s.aw_ok;
    w_now = next_s.w_held;
    w_byte = next_s.w_byte;
    w_lane0 = next_s.w_lane0;
    // -----------------------------------------------------------------
    // write commit
    // -----------------------------------------------------------------
    // both halves present: commit, visible from the next cycle [R7]
    if (aw_now && w_now && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = aw_ok ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
      // only lane 0 carries data; upper lanes have nothing to hold
      if (aw_ok && w_lane0) begin
        case (aw_idx[7:0])
          pcr_pkg::IDX_PORT0_OUTPUT_ENABLE: next_s.oe = w_byte;
          pcr_pkg::IDX_PORT0_LCD_BIAS_ENABLE: next_s.bias = w_byte; // [R1]
          pcr_pkg::IDX_PORT2_PIN_MODE: next_s.pmode = w_byte; // [R2]
          pcr_pkg::IDX_SYSTEM_CONFIG_BITS: next_s.opt = w_byte; // [R3] [R4]
          default: next_s.oe = s.oe;
        endcase
      end
    end
    // the response stands until the master takes it
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    // reads use the stored bytes, so a read on a commit edge sees the
    // old value; the new one shows from the next cycle
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      r_idx = S_AXI_ARADDR[11:2];
      // an unmapped index whose low byte aliases a register reads zero
      if (idx_ok(r_idx)) begin
        case (r_idx[7:0])
          pcr_pkg::IDX_PORT0_OUTPUT_ENABLE: r_val = s.oe;
          pcr_pkg::IDX_PORT0_LCD_BIAS_ENABLE: r_val = s.bias;
          pcr_pkg::IDX_PORT2_PIN_MODE: r_val = s.pmode;
          pcr_pkg::IDX_SYSTEM_CONFIG_BITS: r_val = s.opt;
          default: r_val = 8'h00;
        endcase
      end
      next_s.rvalid = 1'b1;
      next_s.rdata = {24'h000000, r_val}; // [R7]
      next_s.rresp = idx_ok(r_idx) ? pcr_pkg::RESP_OKAY
                                   : pcr_pkg::RESP_SLVERR;
    end else if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  // reset is synchronous: handshake state clears, bytes take reset values
  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
      s.oe <= pcr_pkg::RST_PORT0_OUTPUT_ENABLE;
      s.bias <= pcr_pkg::RST_PORT0_LCD_BIAS_ENABLE; // [R1]
      s.pmode <= pcr_pkg::RST_PORT2_PIN_MODE; // [R2]
      s.opt <= pcr_pkg::RST_SYSTEM_CONFIG_BITS; // [R3] [R4] [R5]
    end else begin
      s <= next_s;
    end
  end

  // -------------------------------------------------------------------
  // fields out to the peripherals
  // -------------------------------------------------------------------
  pcr_decode u_decode (
    .opt(s.opt),
    .pmode(s.pmode),
    .wdt_ms(wdt_ms), // [R5]
    .t3_cycles(t3_cycles), // [R6]
    .pin_undef(pin_undef)
  );

  assign PORT0_OUTPUT_ENABLE = s.oe;
  assign PORT0_LCD_BIAS_ENABLE = s.bias; // [R1]
  assign PIN21_MODE_FIELD = s.pmode[pcr_pkg::PIN21_MODE_LSB +: 2]; // [R2]
  assign PIN20_MODE_FIELD = s.pmode[pcr_pkg::PIN20_MODE_LSB +: 2]; // [R2]
  // code 11 is kept as written; the pad logic decides what to do with it
  assign PIN_MODE_UNDEFINED = pin_undef;
  assign SINGLE_WIRE_UART_ENABLE =
    s.opt[pcr_pkg::SINGLE_WIRE_UART_BIT]; // [R3]
  assign TOUCH_CLOCK_AUTO_ADJUST =
    s.opt[pcr_pkg::TOUCH_CLOCK_ADJUST_BIT]; // [R4]
  assign WATCHDOG_PERIOD_SELECT =
    s.opt[pcr_pkg::WATCHDOG_PERIOD_LSB +: 2]; // [R5]
  // the divider itself lives outside; only its select is stored here
  assign ADC_CLOCK_DIV_SELECT = s.opt[pcr_pkg::ADC_CLOCK_DIV_LSB +: 2];
  assign TIMER3_PERIOD_SELECT =
    s.opt[pcr_pkg::TIMER3_PERIOD_LSB +: 2]; // [R6]
  assign WATCHDOG_PERIOD_MS = wdt_ms;
  assign TIMER3_PERIOD_CYCLES = t3_cycles;
endmodule

// ===== sim/pcr_regs_chk.sv
`timescale 1ns/1ps
module pcr_regs_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic [7:0] PORT0_LCD_BIAS_ENABLE,
  input wire logic [1:0] PIN21_MODE_FIELD,
  input wire logic [1:0] PIN20_MODE_FIELD,
  input wire logic [1:0] PIN_MODE_UNDEFINED,
  input wire logic SINGLE_WIRE_UART_ENABLE,
  input wire logic TOUCH_CLOCK_AUTO_ADJUST,
  input wire logic [1:0] TIMER3_PERIOD_SELECT,
  input wire logic [1:0] WATCHDOG_PERIOD_SELECT,
  input wire logic [8:0] WATCHDOG_PERIOD_MS,
  input wire logic [15:0] TIMER3_PERIOD_CYCLES
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // -------------------------------------------------------------------
  // settings move only on the edge that commits a write
  // -------------------------------------------------------------------
  a_bias_commit: assert property (
    !$stable(PORT0_LCD_BIAS_ENABLE) |-> $rose(S_AXI_BVALID))
    else $error("bias enable moved without a write");
  a_mode_commit: assert property (
    !$stable({PIN21_MODE_FIELD, PIN20_MODE_FIELD}) |-> $rose(S_AXI_BVALID))
    else $error("pin mode moved without a write");
  a_undef_flag: assert property (
    PIN_MODE_UNDEFINED ==
    {PIN21_MODE_FIELD == 2'h3, PIN20_MODE_FIELD == 2'h3})
    else $error("undefined mode flag wrong");
  a_opt_commit: assert property (
    !$stable({SINGLE_WIRE_UART_ENABLE, TOUCH_CLOCK_AUTO_ADJUST,
    WATCHDOG_PERIOD_SELECT, TIMER3_PERIOD_SELECT})
    |-> $rose(S_AXI_BVALID)) else $error("option bit moved without a write");
  a_wdt_period: assert property (
    WATCHDOG_PERIOD_MS == (9'h1E0 >> WATCHDOG_PERIOD_SELECT))
    else $error("watchdog period decode wrong");
  a_t3_period: assert property (
    TIMER3_PERIOD_SELECT == 2'h3 ? TIMER3_PERIOD_CYCLES == 16'h0080
    : TIMER3_PERIOD_CYCLES == (16'h8000 >> (2 * TIMER3_PERIOD_SELECT)))
    else $error("timer3 period decode wrong");
  a_write_resp: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> S_AXI_BVALID) else $error("write response late");
  a_read_resp: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response late");
  a_resp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_one_write: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
  c_stall: cover property (S_AXI_BVALID && !S_AXI_BREADY);
  c_slverr: cover property ($rose(S_AXI_BVALID) && S_AXI_BRESP == 2'h2);
  c_read: cover property ($rose(S_AXI_RVALID));
  c_undef: cover property (PIN_MODE_UNDEFINED != 2'h0);
endmodule
bind pcr_regs pcr_regs_chk pcr_regs_chk_i (.*);

// ===== sim/pcr_regs_tb.sv
`timescale 1ns/1ps
module pcr_regs_tb;
  localparam logic [11:0] ad_oe =
    {2'h0, pcr_pkg::IDX_PORT0_OUTPUT_ENABLE, 2'h0};
  localparam logic [11:0] ad_lb =
    {2'h0, pcr_pkg::IDX_PORT0_LCD_BIAS_ENABLE, 2'h0};
  localparam logic [11:0] ad_pm =
    {2'h0, pcr_pkg::IDX_PORT2_PIN_MODE, 2'h0};
  localparam logic [11:0] ad_op =
    {2'h0, pcr_pkg::IDX_SYSTEM_CONFIG_BITS, 2'h0};
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [11:0] S_AXI_AWADDR = 12'h000, S_AXI_ARADDR = 12'h000;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, SINGLE_WIRE_UART_ENABLE;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, PIN21_MODE_FIELD, PIN20_MODE_FIELD;
  logic [1:0] PIN_MODE_UNDEFINED, WATCHDOG_PERIOD_SELECT;
  logic [1:0] ADC_CLOCK_DIV_SELECT, TIMER3_PERIOD_SELECT;
  logic [7:0] PORT0_OUTPUT_ENABLE, PORT0_LCD_BIAS_ENABLE;
  logic TOUCH_CLOCK_AUTO_ADJUST;
  logic [8:0] WATCHDOG_PERIOD_MS;
  logic [15:0] TIMER3_PERIOD_CYCLES;
  int errors = 0;
  int checked = 0;
  int b_wait = 0;
  pcr_regs pcr_regs_i (.*);
  always #4 CLK = ~CLK;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // #1 lets the edge's register updates land before comparing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    #1;
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge CLK);
    n++;
    if (n > 40) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
    input logic s, input logic [1:0] r);
    int n = 0;
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_WSTRB <= {3'h0, s};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= (b_wait == 0);
    while (!(aw && w)) begin
      tick(n);
      if (!aw && S_AXI_AWREADY) begin
        aw = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (!w && S_AXI_WREADY) begin
        w = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    // a late bready keeps the response waiting
    if (b_wait > 0) begin
      repeat (b_wait) tick(n);
      S_AXI_BREADY <= 1'b1;
    end
    do tick(n); while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    chk(S_AXI_BRESP, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e,
    input logic [1:0] r);
    int n = 0;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do tick(n); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do tick(n); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    chk({S_AXI_RRESP, S_AXI_RDATA[29:0]}, {r, 22'h0, e});
  endtask
  task automatic t_reset();
    rdc(ad_oe, 8'h00, 2'h0);
    rdc(ad_lb, 8'h00, 2'h0);
    rdc(ad_pm, 8'h05, 2'h0);
    rdc(ad_op, 8'h00, 2'h0);
    $display("reset test done");
  endtask
  task automatic t_bias();
    wr(ad_lb, 8'hA5, 1'b1, 2'h0);
    chk(PORT0_LCD_BIAS_ENABLE, 8'hA5);
    wr(ad_lb, 8'h5A, 1'b0, 2'h0);
    rdc(ad_lb, 8'hA5, 2'h0);
    wr(ad_oe, 8'h3C, 1'b1, 2'h0);
    chk(PORT0_OUTPUT_ENABLE, 8'h3C);
    wr(12'h254, 8'hFF, 1'b1, 2'h2);
    rdc(12'h254, 8'h00, 2'h2);
    $display("bias test done");
  endtask
  task automatic t_mode();
    for (int c = 0; c < 4; c++) begin
      wr(ad_pm, {4'h0, 2'(c), 2'(3 - c)}, 1'b1, 2'h0);
      chk({PIN21_MODE_FIELD, PIN20_MODE_FIELD}, c * 5 ^ 3);
      chk(PIN_MODE_UNDEFINED, {c == 3, c == 0});
    end
    rdc(ad_pm, 8'h0C, 2'h0);
    $display("pin mode test done");
  endtask
  task automatic t_opt();
    logic [8:0] ms[4] = '{9'h1E0, 9'h0F0, 9'h078, 9'h03C};
    logic [15:0] cy[4] = '{16'h8000, 16'h2000, 16'h0800, 16'h0080};
    for (int i = 0; i < 4; i++) begin
      wr(ad_op, {2'(i), 2'(i), 2'(3 - i), 2'(i)}, 1'b1, 2'h0);
      chk(SINGLE_WIRE_UART_ENABLE, i / 2);
      chk(TOUCH_CLOCK_AUTO_ADJUST, i % 2);
      chk(WATCHDOG_PERIOD_MS, ms[i]);
      chk(TIMER3_PERIOD_CYCLES, cy[i]);
      chk(WATCHDOG_PERIOD_SELECT, i);
      chk(TIMER3_PERIOD_SELECT, i);
      chk(ADC_CLOCK_DIV_SELECT, 3 - i);
    end
    $display("option test done");
  endtask
  task automatic t_stall();
    b_wait = 3;
    wr(ad_oe, 8'hC3, 1'b1, 2'h0);
    b_wait = 0;
    chk(PORT0_OUTPUT_ENABLE, 8'hC3);
    rdc(ad_oe, 8'hC3, 2'h0);
    $display("stall test done");
  endtask
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    t_bias();
    t_mode();
    t_opt();
    t_stall();
    @(posedge CLK);
    RST <= 1'b1;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    print_verdict();
  end
endmodule
